//--- dv/drive_partner.sv
`timescale 1ns/1ns
`default_nettype none
module drive_partner
  import speed_ref_pkg::*;
#(
  parameter int STEP = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // command from the selector
  input wire drive_out_t drive_out,
  output logic signed [15:0] motor_speed
);
  // the motor slews at a bounded rate and coasts to rest once run drops
  logic signed [15:0] target;
  assign target = drive_out.run ? drive_out.speed_command : 16'sh0;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) motor_speed <= 16'sh0;
    else if (int'(target) - int'(motor_speed) > STEP) motor_speed <= motor_speed + 16'(STEP);
    else if (int'(motor_speed) - int'(target) > STEP) motor_speed <= motor_speed - 16'(STEP);
    else motor_speed <= target;
  end
endmodule : drive_partner
`default_nettype wire

//--- dv/speed_reference_selector_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module speed_reference_selector_assertions
  import speed_ref_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // watched ports
  input wire apb_req_t apb_req,
  input wire apb_rsp_t apb_rsp,
  input wire digital_in_t din,
  input wire drive_out_t drive_out,
  input wire logic [63:0] status_message
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // any request that outranks the remote mode
  logic upper;
  assign upper = din.override_activation_input | din.jog_forward_mode | din.jog_reverse_mode | (|din.user_mode_input);

  apb_answer_a: assert property (ce && apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
    else $error("apb answer late");
  pready_pulse_a: assert property (ce && apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held too long");
  override_mode_a: assert property (ce && din.override_activation_input |=> drive_out.mode == MODE_OVERRIDE)
    else $error("override mode missing");
  override_ramp_a: assert property ((drive_out.mode == MODE_OVERRIDE)[*2] |->
    drive_out.ramp_up_time == drive_out.ramp_down_time && drive_out.ramp_up_time inside {[RAMP_MIN:RAMP_MAX]})
    else $error("override ramp wrong");
  jog_mode_a: assert property (ce && din.jog_forward_mode && !din.override_activation_input |=>
    drive_out.mode == MODE_JOG && drive_out.run)
    else $error("jog not running");
  remote_mode_a: assert property (ce && din.remote_select && !upper |=> drive_out.mode == MODE_REMOTE)
    else $error("remote mode missing");
  message_idle_a: assert property ((drive_out.mode != MODE_USER)[*2] |-> status_message == 64'h0)
    else $error("message shown outside user mode");
  // the run output trails the latch by one cycle, so look two edges on
  stop_wins_a: assert property (ce && !din.stop_n && !upper ##1 ce && !upper |=> !drive_out.run)
    else $error("run survived stop");

  cover property (drive_out.mode == MODE_OVERRIDE);
  cover property (drive_out.mode == MODE_USER && drive_out.run);
  cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule : speed_reference_selector_assertions
`default_nettype wire

//--- dv/speed_reference_selector_test.sv
`timescale 1ns/1ns
`default_nettype none
module speed_reference_selector_test
  import speed_ref_pkg::*;
;
  logic clk, rstn, ce, e;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  digital_in_t din;
  logic signed [15:0] analog_in [3];
  logic signed [15:0] retained_console, console_store, motor_speed;
  drive_out_t drive_out;
  logic [63:0] status_message, msg;
  logic [31:0] lfsr, q;
  logic [15:0] preset [1:8];
  int n_mismatch, compares, cycles;

  speed_reference_selector dut (.clk(clk), .rstn(rstn), .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .din(din), .analog_in(analog_in), .retained_console(retained_console), .drive_out(drive_out),
    .status_message(status_message), .console_store(console_store));
  drive_partner partner (.clk(clk), .rstn(rstn), .drive_out(drive_out), .motor_speed(motor_speed));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_of_test();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // a hang counts as a failure rather than a silent stall
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  // first source is preset seven, second is preset eight
  function automatic logic [15:0] pick(input int p);
    return (p == 1) ? preset[7] : (p == 2) ? preset[8] : preset[p];
  endfunction : pick

  function automatic int pos_of(input int m, input logic [7:0] s);
    int p;
    p = 1;
    if (m == 0) p = {s[0], s[1], s[2]} + 1;
    else if (m == 2) p = ($countones(s) == 0) ? 1 : $countones(s);
    else for (int i = 7; i >= 0; i--) if (s[i]) p = i + 1;
    return p;
  endfunction : pos_of

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    apb_req <= '{paddr:a, psel:1'b1, penable:1'b0, pwrite:w, pwdata:d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) n_mismatch++;
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task automatic pulse_run(input logic stop);
    if (stop) din.stop_n <= 1'b0;
    else din.run_forward_latch <= 1'b1;
    tick(1);
    din.stop_n <= 1'b1;
    din.run_forward_latch <= 1'b0;
    tick(3);
  endtask : pulse_run

  // bits: raise, lower, console up, console down
  task automatic press(input logic [3:0] b, input int n);
    {din.raise_reference_input, din.lower_reference_input, din.console_up, din.console_down} <= b;
    tick(n);
    {din.raise_reference_input, din.lower_reference_input, din.console_up, din.console_down} <= 4'h0;
    tick(1);
  endtask : press

  initial begin
    logic [7:0] s;
    logic [15:0] a, b;
    lfsr = 32'hF86DA2CB;
    n_mismatch = 0;
    compares = 0;
    cycles = 0;
    rstn = 1'b0;
    ce = 1'b1;
    apb_req = '0;
    din = '{stop_n:1'b1, default:'0};
    analog_in = '{default:'0};
    retained_console = 16'h1234;
    tick(5);
    chk(drive_out, 64'h0);
    rstn <= 1'b1;
    tick(3);
    chk($unsigned(console_store), 64'h0);
    apb(1'b0, ADDR_RAMP, 32'h0);
    chk(q, RAMP_RESET);
    for (int i = 1; i <= 8; i++) begin
      preset[i] = 16'(rnd()) & 16'h3FFF;
      apb(1'b1, ADDR_PRESET_BASE + 8'(4 * (i - 1)), {16'h0, preset[i]});
    end
    apb(1'b1, ADDR_SRC, 32'h00A948B3);
    apb(1'b1, ADDR_CTRL, 32'h01230000);
    apb(1'b1, ADDR_USER, 32'h04560065);
    msg = {rnd(), rnd()};
    apb(1'b1, ADDR_MSG0_LO, msg[31:0]);
    apb(1'b1, ADDR_MSG0_HI, msg[63:32]);
    apb(1'b0, 8'h60, 32'h0);
    chk(e, 1'b1);
    pulse_run(1'b0);
    chk($unsigned(drive_out.speed_command), preset[1]);
    din.remote_select <= 1'b1;
    pulse_run(1'b0);
    chk({drive_out.ramp_up_time, drive_out.ramp_down_time}, 32'h04560123);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, ADDR_CTRL, 32'h01230000 | (m << 2));
      for (int k = 0; k < 10; k++) begin
        s = 8'(rnd());
        if (m == 0) s[2:0] = {k[0], k[1], k[2]};
        else if (k == 0) s = (m == 1) ? 8'h40 : 8'h00;
        else if (k == 1) s = 8'hFF;
        else if (k == 2 && m == 2) s = 8'hDD;
        if (s == 8'h00 && m == 1) s = 8'h80;
        din.selector_inputs <= s;
        tick(3);
        chk($unsigned(drive_out.speed_command), pick(pos_of(m, s)));
      end
    end
    apb(1'b1, ADDR_RAMP, 32'h3);
    din.override_activation_input <= 1'b1;
    tick(3);
    chk(drive_out.mode, MODE_OVERRIDE);
    chk($unsigned(drive_out.speed_command), preset[6]);
    chk(drive_out.ramp_up_time, RAMP_MIN);
    apb(1'b1, ADDR_RAMP, 32'h2000);
    tick(2);
    chk(drive_out.ramp_down_time, RAMP_MAX);
    din.override_activation_input <= 1'b0;
    din.jog_forward_mode <= 1'b1;
    tick(3);
    chk({drive_out.mode, drive_out.run}, {MODE_JOG, 1'b1});
    chk($unsigned(drive_out.speed_command), preset[2]);
    apb(1'b1, ADDR_SRC, 32'h05A948B3);
    din.jog_forward_mode <= 1'b0;
    din.jog_reverse_mode <= 1'b1;
    tick(3);
    chk({drive_out.run, drive_out.reverse, drive_out.speed_command}, {2'b11, preset[3]});
    din.jog_reverse_mode <= 1'b0;
    tick(3);
    chk(drive_out.run, 1'b0);
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, ADDR_USER, 32'h04560065 | (c << 8));
      din.user_mode_input <= 2'b01;
      tick(3);
      chk({drive_out.mode, drive_out.speed_command}, {MODE_USER, preset[3]});
      chk(status_message, msg);
      chk(drive_out.run, c != 0);
      din.user_mode_input <= 2'b00;
      tick(3);
      chk(drive_out.run, c == 1);
      pulse_run(1'b1);
      chk(drive_out.run, 1'b0);
    end
    apb(1'b1, ADDR_SRC, 32'h00A948C3);
    // even and never zero, so the mean is exact and both inputs count
    a = (16'(rnd()) & 16'h3FFE) | 16'h0002;
    b = (16'(rnd()) & 16'h3FFE) | 16'h0002;
    analog_in <= '{a, b, 16'sh8005};
    apb(1'b1, ADDR_CTRL, 32'h01230060);
    pulse_run(1'b0);
    chk($unsigned(drive_out.speed_command), (a + b) >> 1);
    analog_in[1] <= 16'sh0;
    tick(3);
    chk($unsigned(drive_out.speed_command), a);
    analog_in[1] <= b;
    apb(1'b1, ADDR_CTRL, 32'h012300F0);
    tick(3);
    chk($unsigned(drive_out.speed_command), (a > b) ? a : b);
    apb(1'b1, ADDR_SRC, 32'h00A94823);
    apb(1'b1, ADDR_CTRL, 32'h01230000);
    press(4'h8, 10);
    press(4'h4, 3);
    press(4'h1, 2);
    press(4'h2, 4);
    // a frozen clock enable must not let the raise input count
    ce <= 1'b0;
    press(4'h8, 5);
    ce <= 1'b1;
    tick(3);
    chk($unsigned(console_store), 64'h9);
    chk($unsigned(drive_out.speed_command), 64'h9);
    pulse_run(1'b1);
    chk($unsigned(console_store), 64'h9);
    apb(1'b1, ADDR_CTRL, 32'h01230002);
    pulse_run(1'b0);
    pulse_run(1'b1);
    chk({drive_out.run, console_store}, 64'h0);
    // long enough for the partner to coast down from the largest preset
    tick(4100);
    chk(motor_speed, 16'h0);
    // second reset with the motor at rest: the keep flag now brings the retained value back
    rstn <= 1'b0;
    tick(2);
    rstn <= 1'b1;
    tick(2);
    chk($unsigned(console_store), 64'h0);
    apb(1'b1, ADDR_CTRL, 32'h01230001);
    tick(2);
    chk($unsigned(console_store), {48'h0, retained_console});
    end_of_test();
  end
endmodule : speed_reference_selector_test

bind speed_reference_selector speed_reference_selector_assertions chk_i (.clk(clk), .rstn(rstn), .ce(ce),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .din(din), .drive_out(drive_out), .status_message(status_message));
`default_nettype wire

//--- inc/speed_ref_pkg.sv
package speed_ref_pkg;
  // reference source codes (a source selector field holds one of these)
  localparam logic [3:0] SRC_ZERO = 4'h0;
  localparam logic [3:0] SRC_ANALOG = 4'h1;
  localparam logic [3:0] SRC_CONSOLE = 4'h2;
  localparam logic [3:0] SRC_PRESET_BASE = 4'h3;
  localparam logic [3:0] SRC_SELECTOR = 4'hB;
  localparam logic [3:0] SRC_COMBINER = 4'hC;

  typedef enum logic [1:0] {
    METHOD_MUX = 2'h0,
    METHOD_MULTI = 2'h1,
    METHOD_TALLY = 2'h2
  } selection_method_t;

  typedef enum logic [1:0] {
    CFG_REF_ONLY = 2'h0,
    CFG_REF_LATCH = 2'h1,
    CFG_REF_START_STOP = 2'h2
  } user_cfg_t;

  // operating modes, gray coded along the usual path
  typedef enum logic [2:0] {
    MODE_LOCAL = 3'h0,
    MODE_REMOTE = 3'h1,
    MODE_USER = 3'h3,
    MODE_JOG = 3'h2,
    MODE_OVERRIDE = 3'h6
  } op_mode_t;

  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SRC = 8'h04;
  localparam logic [7:0] ADDR_USER = 8'h08;
  localparam logic [7:0] ADDR_RAMP = 8'h0C;
  localparam logic [7:0] ADDR_MSG0_LO = 8'h10;
  localparam logic [7:0] ADDR_MSG0_HI = 8'h14;
  localparam logic [7:0] ADDR_MSG1_LO = 8'h18;
  localparam logic [7:0] ADDR_MSG1_HI = 8'h1C;
  localparam logic [7:0] ADDR_PRESET_BASE = 8'h20;
  localparam logic [7:0] ADDR_CONSOLE = 8'h40;
  localparam logic [7:0] ADDR_STATUS = 8'h44;
  localparam logic [7:0] ADDR_SPEED = 8'h48;
  localparam logic [7:0] ADDR_MSG_LO = 8'h4C;
  localparam logic [7:0] ADDR_MSG_HI = 8'h50;

  localparam logic [15:0] RAMP_RESET = 16'h0064;
  localparam logic [15:0] RAMP_MIN = 16'h0005;
  localparam logic [15:0] RAMP_MAX = 16'h1770;
  localparam logic [15:0] CONSOLE_STEP = 16'h0001;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic remote_select;
    logic override_activation_input;
    logic jog_forward_mode;
    logic jog_reverse_mode;
    logic [1:0] user_mode_input;
    logic stop_n;
    logic run_forward_latch;
    logic raise_reference_input;
    logic lower_reference_input;
    logic console_up;
    logic console_down;
    logic [7:0] selector_inputs;
  } digital_in_t;

  typedef struct packed {
    logic signed [15:0] speed_command;
    logic run;
    logic reverse;
    logic [15:0] ramp_up_time;
    logic [15:0] ramp_down_time;
    logic [2:0] mode;
  } drive_out_t;
endpackage : speed_ref_pkg

//--- verilog/speed_reference_selector.sv
`timescale 1ns/1ns
`default_nettype none
module speed_reference_selector
  import speed_ref_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // register bus
  input wire apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  // drive side
  input wire digital_in_t din,
  input wire logic signed [WIDTH-1:0] analog_in [3],
  input wire logic signed [WIDTH-1:0] retained_console,
  output drive_out_t drive_out,
  output logic [63:0] status_message,
  output logic signed [WIDTH-1:0] console_store
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] src;
    logic [31:0] user;
    logic [15:0] ramp;
    logic [3:0][31:0] msg;
    logic [7:0][15:0] preset;
    logic signed [15:0] console;
    logic loaded;
    logic run_latch;
    logic [1:0] user_prev;
    apb_rsp_t rsp;
    drive_out_t out;
    logic [63:0] message;
  } state_t;

  state_t state_reg, state_next;

  // ctrl, src and user fields
  logic keep_console_reference_flag, clear_on_stop_flag;
  selection_method_t selection_method;
  logic analog_combine_function;
  logic [3:0] local_reference_selection, remote_sel, override_reference_selection;
  logic [3:0] jog_sel, jog_reverse_sel, first_configurable_source, second_configurable_source;
  logic [3:0] user_ref [2];
  user_cfg_t user_mode_start_stop_config [2];
  logic [2:0] comb_src_valid;

  assign keep_console_reference_flag = state_reg.ctrl[0];
  assign clear_on_stop_flag = state_reg.ctrl[1];
  assign selection_method = selection_method_t'(state_reg.ctrl[3:2]);
  assign analog_combine_function = state_reg.ctrl[4];
  assign comb_src_valid = state_reg.ctrl[7:5];
  assign local_reference_selection = state_reg.src[3:0];
  assign remote_sel = state_reg.src[7:4];
  assign override_reference_selection = state_reg.src[11:8];
  assign jog_sel = state_reg.src[15:12];
  assign jog_reverse_sel = state_reg.src[27:24];
  assign first_configurable_source = state_reg.src[19:16];
  assign second_configurable_source = state_reg.src[23:20];
  assign user_ref[0] = state_reg.user[3:0];
  assign user_ref[1] = state_reg.user[7:4];
  assign user_mode_start_stop_config[0] = user_cfg_t'(state_reg.user[9:8]);
  assign user_mode_start_stop_config[1] = user_cfg_t'(state_reg.user[11:10]);

  // analog combiner
  // two spare bits: three full-scale inputs cannot overflow the sum
  logic signed [WIDTH+1:0] comb_sum;
  logic [1:0] comb_cnt;
  logic signed [WIDTH-1:0] comb_max, comb_out;
  always_comb begin
    comb_sum = '0;
    comb_cnt = 2'h0;
    // start at the most negative value so a lone negative input still wins
    comb_max = {1'b1, {(WIDTH-1){1'b0}}};
    for (int i = 0; i < 3; i++) begin
      if (comb_src_valid[i]) begin
        if (analog_in[i] != '0) begin
          comb_sum = comb_sum + (WIDTH+2)'(analog_in[i]);
          comb_cnt = comb_cnt + 2'h1;
        end
        if (analog_in[i] > comb_max) begin
          comb_max = analog_in[i];
        end
      end
    end
    if (analog_combine_function) begin
      comb_out = (comb_src_valid == 3'h0) ? '0 : comb_max;
    end else if (comb_cnt == 2'h0) begin
      comb_out = '0;
    end else begin
      comb_out = WIDTH'(comb_sum / $signed({1'b0, comb_cnt}));
    end
  end

  // reference selector index 0..7
  logic [2:0] sel_idx;
  logic [3:0] tally;
  always_comb begin
    sel_idx = 3'h0;
    tally = 4'h0;
    case (selection_method)
      METHOD_MUX: begin
        // bit order: selector one is the msb, selector three the lsb
        sel_idx = {din.selector_inputs[0], din.selector_inputs[1], din.selector_inputs[2]};
      end
      METHOD_MULTI: begin
        for (int i = 7; i >= 0; i--) begin
          if (din.selector_inputs[i]) begin
            sel_idx = 3'(i);
          end
        end
      end
      METHOD_TALLY: begin
        for (int i = 0; i < 8; i++) begin
          tally = tally + {3'h0, din.selector_inputs[i]};
        end
        // a count of n selects position n; none active gives position one
        sel_idx = (tally == 4'h0) ? 3'h0 : 3'(tally - 4'h1);
      end
      default: sel_idx = 3'h0;
    endcase
  end

  logic signed [15:0] selector_value;

  // the selector's value comes in as an argument, so the selector never
  // reads itself through this function and no combinational loop forms
  function automatic logic signed [15:0] source_value(input logic [3:0] code, input logic signed [15:0] sel_val);
    source_value = '0;
    if (code == SRC_ANALOG) begin
      source_value = analog_in[0];
    end else if (code == SRC_CONSOLE) begin
      source_value = state_reg.console;
    end else if (code >= SRC_PRESET_BASE && code < SRC_SELECTOR) begin
      source_value = state_reg.preset[3'(code - SRC_PRESET_BASE)];
    end else if (code == SRC_COMBINER) begin
      source_value = comb_out;
    end else if (code == SRC_SELECTOR) begin
      source_value = sel_val;
    end
  endfunction : source_value

  // a selector entry that names the selector itself reads as zero
  always_comb begin
    if (sel_idx == 3'h0) begin
      selector_value = source_value(first_configurable_source, 16'sh0);
    end else if (sel_idx == 3'h1) begin
      selector_value = source_value(second_configurable_source, 16'sh0);
    end else begin
      selector_value = state_reg.preset[sel_idx];
    end
  end

  // mode resolution: override > jog > user modes > remote/local
  op_mode_t mode;
  logic user_active;
  logic user_idx;
  logic jog_any;
  assign jog_any = din.jog_forward_mode | din.jog_reverse_mode;
  always_comb begin
    user_active = din.user_mode_input[0] | din.user_mode_input[1];
    user_idx = !din.user_mode_input[0];
    if (din.override_activation_input) begin
      mode = MODE_OVERRIDE;
    end else if (jog_any) begin
      mode = MODE_JOG;
    end else if (user_active) begin
      mode = MODE_USER;
    end else if (din.remote_select) begin
      mode = MODE_REMOTE;
    end else begin
      mode = MODE_LOCAL;
    end
  end

  logic [3:0] active_src;
  logic run_now, stop_cmd;
  logic hold_run;
  always_comb begin
    case (mode)
      MODE_OVERRIDE: active_src = override_reference_selection;
      MODE_JOG: active_src = din.jog_forward_mode ? jog_sel : jog_reverse_sel;
      MODE_USER: active_src = user_ref[user_idx];
      MODE_REMOTE: active_src = remote_sel;
      MODE_LOCAL: active_src = local_reference_selection;
      default: active_src = SRC_ZERO;
    endcase
    // held-input user modes run only while asserted
    hold_run = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (din.user_mode_input[i] && user_mode_start_stop_config[i] == CFG_REF_START_STOP) begin
        hold_run = 1'b1;
      end
    end
    // the run output follows the latch one cycle late, so a stop needs two
    // edges to reach the run output; the latch itself clears at once
    run_now = jog_any | hold_run | state_reg.run_latch;
    stop_cmd = state_reg.out.run && !run_now;
  end

  // bus access
  logic bus_access, wr, rd_hit;
  logic [31:0] rdata;
  assign bus_access = apb_req.psel && apb_req.penable;
  assign wr = bus_access && apb_req.pwrite;
  always_comb begin
    rd_hit = 1'b1;
    rdata = 32'h0;
    case (apb_req.paddr)
      ADDR_CTRL: rdata = state_reg.ctrl;
      ADDR_SRC: rdata = state_reg.src;
      ADDR_USER: rdata = state_reg.user;
      ADDR_RAMP: rdata = {16'h0, state_reg.ramp};
      ADDR_MSG0_LO: rdata = state_reg.msg[0];
      ADDR_MSG0_HI: rdata = state_reg.msg[1];
      ADDR_MSG1_LO: rdata = state_reg.msg[2];
      ADDR_MSG1_HI: rdata = state_reg.msg[3];
      ADDR_CONSOLE: rdata = {{16{state_reg.console[15]}}, state_reg.console};
      ADDR_STATUS: rdata = {26'h0, state_reg.out.mode, state_reg.run_latch, state_reg.out.run, state_reg.loaded};
      ADDR_SPEED: rdata = {{16{state_reg.out.speed_command[15]}}, state_reg.out.speed_command};
      ADDR_MSG_LO: rdata = state_reg.message[31:0];
      ADDR_MSG_HI: rdata = state_reg.message[63:32];
      default: begin
        if (apb_req.paddr >= ADDR_PRESET_BASE && apb_req.paddr < ADDR_CONSOLE && apb_req.paddr[1:0] == 2'h0) begin
          rdata = {16'h0, state_reg.preset[apb_req.paddr[4:2]]};
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;
    state_next.rsp.pready = 1'b0;
    state_next.rsp.pslverr = 1'b0;
    // one wait state: answer comes the cycle after the access phase starts
    if (bus_access && !state_reg.rsp.pready) begin
      state_next.rsp.pready = 1'b1;
      state_next.rsp.pslverr = !rd_hit;
      state_next.rsp.prdata = apb_req.pwrite ? 32'h0 : rdata;
      if (wr && rd_hit) begin
        case (apb_req.paddr)
          ADDR_CTRL: state_next.ctrl = apb_req.pwdata;
          ADDR_SRC: state_next.src = apb_req.pwdata;
          ADDR_USER: state_next.user = apb_req.pwdata;
          ADDR_RAMP: begin
            // out-of-range ramp writes are clamped to the legal span
            if (apb_req.pwdata[15:0] < RAMP_MIN) begin
              state_next.ramp = RAMP_MIN;
            end else if (apb_req.pwdata[15:0] > RAMP_MAX) begin
              state_next.ramp = RAMP_MAX;
            end else begin
              state_next.ramp = apb_req.pwdata[15:0];
            end
          end
          ADDR_MSG0_LO: state_next.msg[0] = apb_req.pwdata;
          ADDR_MSG0_HI: state_next.msg[1] = apb_req.pwdata;
          ADDR_MSG1_LO: state_next.msg[2] = apb_req.pwdata;
          ADDR_MSG1_HI: state_next.msg[3] = apb_req.pwdata;
          ADDR_CONSOLE: state_next.console = apb_req.pwdata[15:0];
          default: begin
            if (apb_req.paddr >= ADDR_PRESET_BASE && apb_req.paddr < ADDR_CONSOLE) begin
              state_next.preset[apb_req.paddr[4:2]] = apb_req.pwdata[15:0];
            end
          end
        endcase
      end
    end

    // power-up load of the console reference: reset clears ctrl and with it
    // the keep flag, so the load waits for the first ctrl write, which brings it
    // until then the console leaves zero only through a bus write to ADDR_CONSOLE and ignores the buttons
    if (!state_reg.loaded) begin
      if (wr && !state_reg.rsp.pready && apb_req.paddr == ADDR_CTRL) begin
        state_next.loaded = 1'b1;
        state_next.console = apb_req.pwdata[0] ? retained_console : '0;
      end
    end else if (clear_on_stop_flag && stop_cmd) begin
      state_next.console = '0;
    end else if ((din.console_up || din.raise_reference_input) && !(din.console_down || din.lower_reference_input)) begin
      if (state_reg.console != 16'sh7FFF) begin
        state_next.console = state_reg.console + CONSOLE_STEP;
      end
    end else if ((din.console_down || din.lower_reference_input) && !(din.console_up || din.raise_reference_input)) begin
      if (state_reg.console != 16'sh8001) begin
        state_next.console = state_reg.console - CONSOLE_STEP;
      end
    end
    // without clear-on-stop a stop leaves the value alone

    // run latch
    // previous user inputs: the latch mode starts on a rising edge only
    state_next.user_prev = din.user_mode_input;
    if (jog_any) begin
      state_next.run_latch = 1'b0;
    end else if (!din.stop_n) begin
      state_next.run_latch = 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (din.user_mode_input[i] && user_mode_start_stop_config[i] == CFG_REF_START_STOP) begin
          state_next.run_latch = 1'b0;
        end else if (din.user_mode_input[i] && !state_reg.user_prev[i]
                     && user_mode_start_stop_config[i] == CFG_REF_LATCH) begin
          state_next.run_latch = 1'b1;
        end
      end
      // reference-only inputs leave the latch untouched
      if (din.run_forward_latch) begin
        state_next.run_latch = 1'b1;
      end
    end

    state_next.out.mode = mode;
    state_next.out.run = run_now;
    // override always runs forward, even with reverse jog held
    state_next.out.reverse = din.jog_reverse_mode && !din.override_activation_input;
    state_next.out.speed_command = source_value(active_src, selector_value);
    if (mode == MODE_OVERRIDE) begin
      state_next.out.ramp_up_time = state_reg.ramp;
      state_next.out.ramp_down_time = state_reg.ramp;
    end else begin
      state_next.out.ramp_up_time = state_reg.user[31:16];
      state_next.out.ramp_down_time = state_reg.ctrl[31:16];
    end
    state_next.message = (mode == MODE_USER) ? {state_reg.msg[{user_idx, 1'b1}], state_reg.msg[{user_idx, 1'b0}]}
                                              : 64'h0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
      // the override ramp comes up at its default, not at zero
      state_reg.ramp <= RAMP_RESET;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign apb_rsp = state_reg.rsp;
  assign drive_out = state_reg.out;
  assign status_message = state_reg.message;
  assign console_store = state_reg.console;

endmodule : speed_reference_selector
`default_nettype wire
